// ### inc/eecc_map.svh
/*
  Register offsets, field positions, command codes and timing counts of the
  command controller. Assumes byte addresses on a 32-bit APB, one word per register.
*/
// Summary of operation
// - seven-bit command, usable only during sequence
// - accept 05, 20, 40; others flag error
// - also accept 41, 47, 60
// - address buffer drops the byte select bit
// - address/data buffers read zero outside special mode
// - slow timing tick; two-stage command queue
// - empty and complete flags raise enabled requests
// - divider write sets loaded bit
// - no divider load: command fails, error set
// - array write captures address and data
// - array write with buffer full overwrites, sets empty
// - launch clears complete flag same cycle
// - empty flag sets four cycles after launch
// - abort keeps empty flag clear until done
// - buffered waits; abort launches at once when idle or erasing
// - complete only when nothing active or buffered
// - writing zero to empty flag aborts sequence
// - access error and violation flags clear by writing one
// - protected target sets violation, blocks launches
// - valid launch clears the blank result
`ifndef EECC_MAP_SVH
`define EECC_MAP_SVH

`define EE_OFF_DIV 13'h0000
`define EE_OFF_CFG 13'h0004
`define EE_OFF_STAT 13'h0008
`define EE_OFF_CMD 13'h000C
`define EE_OFF_FT3 13'h0010
`define EE_OFF_AHI 13'h0014
`define EE_OFF_ALO 13'h0018
`define EE_OFF_DHI 13'h001C
`define EE_OFF_DLO 13'h0020
`define EE_ARRAY_BIT 12

`define EE_DIV_LOADED 7
`define EE_DIV_PRESCALE 6
`define EE_CFG_BEIE 7
`define EE_CFG_COMPLETE_IRQ_ENABLE 6
`define EE_ST_BUFFER_EMPTY_FLAG 7
`define EE_ST_COMMAND_COMPLETE_FLAG 6
`define EE_ST_PROTECTION_VIOLATION_FLAG 5
`define EE_ST_ACCESS_ERROR_FLAG 4
`define EE_ST_BLANK 2

`define EE_CMD_VERIFY 7'h05
`define EE_CMD_PROGRAM 7'h20
`define EE_CMD_SECTOR 7'h40
`define EE_CMD_MASS 7'h41
`define EE_CMD_ABORT 7'h47
`define EE_CMD_MODIFY 7'h60

`define EE_CBE_DELAY 3'h4
`define EE_OP_TICKS 12'h01E
`define EE_ABORT_TICKS 12'h004
`define EE_VERIFY_CYCLES 12'h80E
`define EE_PRESCALE_MAX 3'h7

`endif

// ### inc/eecc_pkg.sv
/*
  Types of the command controller: sequence states and the array operation
  request. Assumes the constants of eecc_map.svh.
*/
`default_nettype none
package eecc_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} eecc_seq_t;
  typedef struct packed {
    logic [6:0] cmd;
    logic [11:1] addr;
    logic [15:0] data;
  } eecc_op_t;
endpackage
`default_nettype wire

// ### verification/eecc_apb_host.sv
/*
  APB master standing in for the processor core on the register bus.
  Assumes a free-running pclk and a slave that answers with pready.
*/
`default_nettype none
module eecc_apb_host (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [12:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  int hangs;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0000;
    pwdata = 32'h00000000;
    hangs = 0;
  end
  // entered just after a rising edge; request held until pready is sampled
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
      input bit last, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) hangs++;
    q = prdata;
    e = pslverr;
    if (last) begin
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not look like a still valid request
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ### verification/test_eeprom_command_controller.sv
/*
  Self-checking bench of the command controller: random and corner-case
  command sequences over APB. Assumes eecc_ctrl, eecc_apb_host, eecc_map.svh.
*/
`include "eecc_map.svh"
`default_nettype none
module test_eeprom_command_controller;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic special_mode, prot_enable, blank_result, op_start, irq_buffer_empty, irq_complete;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, q, r1, r2;
  logic [11:0] prot_limit;
  logic [15:0] lfsr;
  eecc_pkg::eecc_op_t op_req, op_seen;
  int errors, cmp_count;
  int nstart = 0;
  logic [6:0] cmds [5] = '{`EE_CMD_VERIFY, `EE_CMD_PROGRAM, `EE_CMD_SECTOR,
      `EE_CMD_MASS, `EE_CMD_MODIFY};

  eecc_ctrl i_eecc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode(special_mode), .prot_enable(prot_enable),
    .prot_limit(prot_limit), .blank_result(blank_result), .op_req(op_req),
    .op_start(op_start), .irq_buffer_empty(irq_buffer_empty), .irq_complete(irq_complete));
  eecc_apb_host i_eecc_apb_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic bit valid_cmd(input logic [6:0] c);
    return c inside {`EE_CMD_VERIFY, `EE_CMD_PROGRAM, `EE_CMD_SECTOR, `EE_CMD_MASS,
      `EE_CMD_ABORT, `EE_CMD_MODIFY};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    i_eecc_apb_host.xfer(1'b1, a, d, 1'b1, q, e);
  endtask
  task automatic rd(input logic [12:0] a);
    i_eecc_apb_host.xfer(1'b0, a, 32'h00000000, 1'b1, q, e);
  endtask
  task automatic stat_is(input string what, input logic [7:0] m, input logic [7:0] v);
    rd(`EE_OFF_STAT);
    chk(what, {24'h000000, v}, q & {24'h000000, m});
  endtask
  // three steps, errors left as they are, launch then back-to-back reads
  task automatic seq(input logic [11:0] a, input logic [15:0] d, input logic [6:0] c);
    wr({1'b1, a}, {16'h0000, d});
    wr(`EE_OFF_CMD, {25'h0000000, c});
    i_eecc_apb_host.xfer(1'b1, `EE_OFF_STAT, 32'h00000080, 1'b0, q, e);
    i_eecc_apb_host.xfer(1'b0, `EE_OFF_STAT, 32'h00000000, 1'b0, r1, e);
    i_eecc_apb_host.xfer(1'b0, `EE_OFF_STAT, 32'h00000000, 1'b1, r2, e);
  endtask
  task automatic wait_cc();
    int n;
    n = 0;
    do begin
      rd(`EE_OFF_STAT);
      n++;
    end while (q[`EE_ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 2000);
    chk("command_complete_flag", 32'h1, {31'h0, q[`EE_ST_COMMAND_COMPLETE_FLAG]});
  endtask
  task automatic summarize();
    errors += i_eecc_apb_host.hangs;
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (op_start === 1'b1) begin
      nstart <= nstart + 1;
      op_seen <= op_req;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #400000;
    errors++;
    summarize();
  end
  initial begin
    logic [11:0] a;
    logic [15:0] d;
    logic [6:0] c;
    int n0;
    errors = 0;
    cmp_count = 0;
    lfsr = 16'h37E3;
    presetn = 1'b0;
    special_mode = 1'b0;
    prot_enable = 1'b0;
    prot_limit = 12'h800;
    blank_result = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    stat_is("reset status", 8'hFF, 8'hC0);
    rd(`EE_OFF_DIV);
    chk("divider loaded", 32'h0, {31'h0, q[`EE_DIV_LOADED]});
    rd(13'h0024);
    chk("unmapped", 32'h1, {31'h0, e});
    seq(12'h010, 16'h1234, `EE_CMD_PROGRAM);
    stat_is("no divider", 8'h10, 8'h10);
    chk("no start", 32'd0, nstart);
    wr(`EE_OFF_STAT, 32'h00000010);
    stat_is("access_error_flag w1c", 8'h10, 8'h00);
    // short divide keeps the run small at 125 MHz
    wr(`EE_OFF_DIV, 32'h00000001);
    rd(`EE_OFF_DIV);
    chk("divider", 32'h81, q);
    for (int i = 0; i < 6; i++) begin
      do c = 7'(rnd()); while (valid_cmd(c));
      wr({1'b1, 12'(rnd())}, 32'h0);
      wr(`EE_OFF_CMD, {25'h0, c});
      stat_is("bad code", 8'h10, 8'h10);
      wr(`EE_OFF_STAT, 32'h00000010);
    end
    wr(`EE_OFF_CFG, 32'h000000C0);
    special_mode <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      a = 12'(rnd());
      d = rnd();
      n0 = nstart;
      wr({1'b1, a}, {16'h0, d});
      rd(`EE_OFF_ALO);
      chk("addr low", {24'h0, a[7:1], 1'b0}, q);
      rd(`EE_OFF_AHI);
      chk("addr high", {28'h0, a[11:8]}, q);
      rd(`EE_OFF_DLO);
      chk("data low", {24'h0, d[7:0]}, q);
      wr(`EE_OFF_CMD, {24'h0, 1'b1, cmds[i]});
      rd(`EE_OFF_CMD);
      chk("cmd read", {25'h0, cmds[i]}, q);
      i_eecc_apb_host.xfer(1'b1, `EE_OFF_STAT, 32'h00000080, 1'b0, q, e);
      i_eecc_apb_host.xfer(1'b0, `EE_OFF_STAT, 32'h00000000, 1'b0, r1, e);
      i_eecc_apb_host.xfer(1'b0, `EE_OFF_STAT, 32'h00000000, 1'b1, r2, e);
      chk("launch flags", 32'h0, r1 & 32'hC0);
      chk("empty early", 32'h0, r2 & 32'h80);
      rd(`EE_OFF_STAT);
      chk("empty at four", 32'h80, q & 32'h80);
      if (i == 1) chk("blank cleared", 32'h0, q & 32'h04);
      chk("one start", n0 + 1, nstart);
      chk("op cmd", {25'h0, cmds[i]}, {25'h0, op_seen.cmd});
      chk("op", {5'h00, a[11:1], d}, {5'h00, op_seen.addr, op_seen.data});
      wait_cc();
      if (i == 0) chk("blank", 32'h04, q & 32'h04);
      chk("irqs", 32'h3, {30'h0, irq_buffer_empty, irq_complete});
    end
    n0 = nstart;
    seq(12'h100, rnd(), `EE_CMD_PROGRAM);
    seq(12'h104, rnd(), `EE_CMD_SECTOR);
    chk("queued waits", n0 + 1, nstart);
    for (int n = 0; n < 2000 && nstart < n0 + 2; n++) @(posedge pclk);
    stat_is("cc with queue", 8'h40, 8'h00);
    wait_cc();
    chk("second op", {25'h0, `EE_CMD_SECTOR}, {25'h0, op_seen.cmd});
    seq(12'h200, 16'h0000, `EE_CMD_SECTOR);
    n0 = nstart;
    seq(12'h200, 16'h0000, `EE_CMD_ABORT);
    chk("abort at once", n0 + 1, nstart);
    chk("abort empty", 32'h0, (r2 & 32'h80));
    rd(`EE_OFF_STAT);
    chk("abort empty late", 32'h0, q & 32'h80);
    wait_cc();
    chk("abort error", 32'h10, q & 32'h10);
    wr(`EE_OFF_STAT, 32'h00000010);
    // a new first step while a command is queued drops that command
    n0 = nstart;
    seq(12'h100, 16'h0001, `EE_CMD_PROGRAM);
    seq(12'h104, 16'h0002, `EE_CMD_PROGRAM);
    wr(13'h1108, 32'h00000003);
    stat_is("overwrite empty", 8'h80, 8'h80);
    wr(`EE_OFF_STAT, 32'h00000000);
    wr(`EE_OFF_STAT, 32'h00000010);
    wait_cc();
    chk("queued dropped", n0 + 1, nstart);
    special_mode <= 1'b0;
    n0 = nstart;
    wr(13'h1300, 32'h0000ABCD);
    rd(`EE_OFF_DLO);
    chk("data hidden", 32'h0, q);
    wr(`EE_OFF_STAT, 32'h00000000);
    stat_is("seq abort", 8'h10, 8'h10);
    wr(`EE_OFF_STAT, 32'h00000010);
    prot_enable <= 1'b1;
    seq(12'hA00, 16'h5555, `EE_CMD_PROGRAM);
    stat_is("protected", 8'h30, 8'h20);
    chk("blocked", n0, nstart);
    wr(13'h1010, 32'h00000000);
    wr(`EE_OFF_CMD, {25'h0, `EE_CMD_PROGRAM});
    rd(`EE_OFF_CMD);
    chk("no sequence", 32'h0, q);
    wr(`EE_OFF_STAT, 32'h00000020);
    stat_is("protection_violation_flag w1c", 8'h20, 8'h00);
    wr(`EE_OFF_CFG, 32'h00000000);
    @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq_complete});
    summarize();
  end
endmodule
`default_nettype wire

// ### verilog/eecc_ctrl.sv
/*
  Command controller of a word-addressed nonvolatile array: APB registers,
  three-step command sequence, two-stage command queue, status flags and
  the divided timing tick. Assumes an APB master with pclk at 125 MHz and an
  array engine that acts on op_start / op_req; protection limits and mode
  come in as levels.
*/
// Design decisions made here: the register offsets and the APB slave port.
`include "eecc_map.svh"
`default_nettype none
module eecc_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode, protection and blank result
  input wire logic special_mode,
  input wire logic prot_enable,
  input wire logic [11:0] prot_limit,
  input wire logic blank_result,
  // array engine
  output eecc_pkg::eecc_op_t op_req,
  output logic op_start,
  // interrupt requests
  output logic irq_buffer_empty,
  output logic irq_complete
);

  function automatic logic is_valid_cmd(input logic [6:0] c);
    return c == `EE_CMD_VERIFY || c == `EE_CMD_PROGRAM || c == `EE_CMD_SECTOR ||
           c == `EE_CMD_MASS || c == `EE_CMD_ABORT || c == `EE_CMD_MODIFY;
  endfunction

  function automatic logic is_erase(input logic [6:0] c);
    return c == `EE_CMD_SECTOR || c == `EE_CMD_MODIFY;
  endfunction

  function automatic logic is_protected(input logic [6:0] c, input logic [11:1] a);
    if (c == `EE_CMD_MASS) begin
      return prot_enable;
    end
    if (c == `EE_CMD_VERIFY || c == `EE_CMD_ABORT) begin
      return 1'b0;
    end
    return prot_enable && ({a, 1'b0} >= prot_limit);
  endfunction

  // bus state
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  // core state
  eecc_pkg::eecc_seq_t seq_r, seq_nxt;
  eecc_pkg::eecc_op_t buf_r, buf_nxt, act_r, act_nxt;
  logic bufv_r, bufv_nxt, busy_r, busy_nxt, abort_r, abort_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [2:0] cbe_cnt_r, cbe_cnt_nxt, pre_cnt_r, pre_cnt_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic buffer_empty_flag_r, buffer_empty_flag_nxt, command_complete_flag_r, command_complete_flag_nxt, protection_violation_flag_r, protection_violation_flag_nxt;
  logic access_error_flag_r, access_error_flag_nxt, blank_r, blank_nxt;
  logic [6:0] div_r, div_nxt;
  logic divld_r, divld_nxt;
  logic [1:0] cfg_r, cfg_nxt;
  logic op_start_r, op_start_nxt, irq_be_r, irq_be_nxt, irq_cc_r, irq_cc_nxt;

  logic setup, wr, in_array, launch_try, launch_ok, tick, done;
  logic [7:0] wb;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready_r && pwrite;
  assign in_array = paddr[`EE_ARRAY_BIT];
  assign wb = pwdata[7:0];
  assign launch_try = wr && !in_array && paddr == `EE_OFF_STAT && wb[`EE_ST_BUFFER_EMPTY_FLAG] &&
                      seq_r == eecc_pkg::SEQ_CMD;
  assign launch_ok = launch_try && divld_r && !protection_violation_flag_r && !access_error_flag_r &&
                     !is_protected(buf_r.cmd, buf_r.addr);

  // no wait state; read data comes from a flop loaded in the setup cycle
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = 1'b0;
    if (setup) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (!in_array) begin
        case (paddr)
          `EE_OFF_DIV: prdata_nxt[7:0] = {divld_r, div_r};
          `EE_OFF_CFG: prdata_nxt[7:6] = cfg_r;
          `EE_OFF_STAT: prdata_nxt[7:0] = {buffer_empty_flag_r, command_complete_flag_r, protection_violation_flag_r, access_error_flag_r, 1'b0,
                                          blank_r, 2'h0};
          // command readable only inside a sequence
          `EE_OFF_CMD: prdata_nxt[6:0] = (seq_r != eecc_pkg::SEQ_IDLE) ? buf_r.cmd : 7'h00;
          `EE_OFF_FT3: prdata_nxt = 32'h0000_0000;
          // buffers visible only in special mode
          `EE_OFF_AHI: prdata_nxt[7:0] = special_mode ? {4'h0, buf_r.addr[11:8]} : 8'h00;
          `EE_OFF_ALO: prdata_nxt[7:0] = special_mode ? {buf_r.addr[7:1], 1'b0} : 8'h00;
          `EE_OFF_DHI: prdata_nxt[7:0] = special_mode ? buf_r.data[15:8] : 8'h00;
          `EE_OFF_DLO: prdata_nxt[7:0] = special_mode ? buf_r.data[7:0] : 8'h00;
          default: pslverr_nxt = 1'b1;
        endcase
      end
    end else if (psel && penable && pready_r) begin
      pready_nxt = 1'b0;
    end else begin
      pready_nxt = pready_r;
      pslverr_nxt = pslverr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // timing tick from prescaler and divider
  assign tick = (!div_r[`EE_DIV_PRESCALE] || pre_cnt_r == `EE_PRESCALE_MAX) &&
                div_cnt_r == div_r[5:0];
  assign done = busy_r && cnt_r == 12'h000 &&
                (act_r.cmd == `EE_CMD_VERIFY || tick);

  always_comb begin
    seq_nxt = seq_r;
    buf_nxt = buf_r;
    act_nxt = act_r;
    bufv_nxt = bufv_r;
    busy_nxt = busy_r;
    abort_nxt = abort_r;
    cnt_nxt = cnt_r;
    cbe_cnt_nxt = (cbe_cnt_r != 3'h0) ? cbe_cnt_r - 3'h1 : 3'h0;
    pre_cnt_nxt = pre_cnt_r;
    div_cnt_nxt = div_cnt_r;
    buffer_empty_flag_nxt = buffer_empty_flag_r;
    command_complete_flag_nxt = command_complete_flag_r;
    protection_violation_flag_nxt = protection_violation_flag_r;
    access_error_flag_nxt = access_error_flag_r;
    blank_nxt = blank_r;
    div_nxt = div_r;
    divld_nxt = divld_r;
    cfg_nxt = cfg_r;
    op_start_nxt = 1'b0;

    if (busy_r) begin
      pre_cnt_nxt = pre_cnt_r + 3'h1;
      if (!div_r[`EE_DIV_PRESCALE] || pre_cnt_r == `EE_PRESCALE_MAX) begin
        div_cnt_nxt = (div_cnt_r == div_r[5:0]) ? 6'h00 : div_cnt_r + 6'h01;
      end
      if (act_r.cmd == `EE_CMD_VERIFY || tick) begin
        cnt_nxt = (cnt_r != 12'h000) ? cnt_r - 12'h001 : 12'h000;
      end
    end else begin
      pre_cnt_nxt = 3'h0;
      div_cnt_nxt = 6'h00;
    end

    // register writes; error clears first so a same-cycle set wins
    if (wr && !in_array) begin
      case (paddr)
        `EE_OFF_DIV: begin
          if (!divld_r) begin
            div_nxt = wb[6:0];
          end
          divld_nxt = 1'b1;
        end
        `EE_OFF_CFG: cfg_nxt = wb[7:6];
        `EE_OFF_STAT: begin
          if (wb[`EE_ST_PROTECTION_VIOLATION_FLAG]) begin
            protection_violation_flag_nxt = 1'b0;
          end
          if (wb[`EE_ST_ACCESS_ERROR_FLAG]) begin
            access_error_flag_nxt = 1'b0;
          end
        end
        `EE_OFF_AHI: if (special_mode) buf_nxt.addr[11:8] = wb[3:0];
        `EE_OFF_ALO: if (special_mode) buf_nxt.addr[7:1] = wb[7:1];
        `EE_OFF_DHI: if (special_mode) buf_nxt.data[15:8] = wb;
        `EE_OFF_DLO: if (special_mode) buf_nxt.data[7:0] = wb;
        default: ;
      endcase
    end

    // completion first, so a launch in the same cycle below overrides it
    if (done) begin
      if (act_r.cmd == `EE_CMD_VERIFY) begin
        blank_nxt = blank_result;
      end
      if (abort_r) begin
        abort_nxt = 1'b0;
        buffer_empty_flag_nxt = 1'b1;
      end
      busy_nxt = 1'b0;
      if (bufv_r && access_error_flag_r) begin
        bufv_nxt = 1'b0;
      end
      if (!bufv_r || access_error_flag_r) begin
        command_complete_flag_nxt = 1'b1;
      end
    end

    if (wr) begin
      case (seq_r)
        eecc_pkg::SEQ_IDLE: begin
          if (in_array && !access_error_flag_r && !protection_violation_flag_r) begin
            buf_nxt.addr = paddr[11:1];
            buf_nxt.data = pwdata[15:0];
            seq_nxt = eecc_pkg::SEQ_ADDR;
            if (!buffer_empty_flag_r && !abort_r) begin
              bufv_nxt = 1'b0;
              buffer_empty_flag_nxt = 1'b1;
            end
          end
        end
        eecc_pkg::SEQ_ADDR: begin
          seq_nxt = eecc_pkg::SEQ_IDLE;
          if (!in_array && paddr == `EE_OFF_CMD) begin
            buf_nxt.cmd = pwdata[6:0];
            // unknown code is an access error
            if (is_valid_cmd(pwdata[6:0])) begin
              seq_nxt = eecc_pkg::SEQ_CMD;
            end else begin
              access_error_flag_nxt = 1'b1;
            end
          end else if (!in_array && paddr == `EE_OFF_STAT && !wb[`EE_ST_BUFFER_EMPTY_FLAG]) begin
            access_error_flag_nxt = 1'b1;
          end else begin
            access_error_flag_nxt = 1'b1;
          end
        end
        eecc_pkg::SEQ_CMD: begin
          seq_nxt = eecc_pkg::SEQ_IDLE;
          if (launch_ok) begin
            buffer_empty_flag_nxt = 1'b0;
            command_complete_flag_nxt = 1'b0;
            blank_nxt = 1'b0;
            if (buf_r.cmd == `EE_CMD_ABORT) begin
              // abort runs at once when idle or erasing, empty held clear
              abort_nxt = 1'b1;
              if (!busy_r || is_erase(act_r.cmd)) begin
                access_error_flag_nxt = busy_r;
                busy_nxt = 1'b1;
                act_nxt = buf_r;
                cnt_nxt = `EE_ABORT_TICKS - 12'h001;
                op_start_nxt = 1'b1;
              end
            end else begin
              bufv_nxt = 1'b1;
              cbe_cnt_nxt = `EE_CBE_DELAY - 3'h1;
            end
          end else if (launch_try && is_protected(buf_r.cmd, buf_r.addr) && divld_r) begin
            protection_violation_flag_nxt = 1'b1;
          end else begin
            access_error_flag_nxt = 1'b1;
          end
        end
        default: seq_nxt = eecc_pkg::SEQ_IDLE;
      endcase
    end

    if ((!busy_r || done) && bufv_r && !access_error_flag_r) begin
      bufv_nxt = 1'b0;
      busy_nxt = 1'b1;
      act_nxt = buf_r;
      op_start_nxt = 1'b1;
      cnt_nxt = (buf_r.cmd == `EE_CMD_VERIFY) ? `EE_VERIFY_CYCLES - 12'h001 :
                `EE_OP_TICKS - 12'h001;
    end

    // empty flag once the queue stage is free
    if (!buffer_empty_flag_r && cbe_cnt_r == 3'h0 && !bufv_r && !abort_r && !launch_ok) begin
      buffer_empty_flag_nxt = 1'b1;
    end

    irq_be_nxt = buffer_empty_flag_nxt && cfg_nxt[1];
    irq_cc_nxt = command_complete_flag_nxt && cfg_nxt[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= eecc_pkg::SEQ_IDLE;
      buf_r <= '0;
      act_r <= '0;
      bufv_r <= 1'b0;
      busy_r <= 1'b0;
      abort_r <= 1'b0;
      cnt_r <= 12'h000;
      cbe_cnt_r <= 3'h0;
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      buffer_empty_flag_r <= 1'b1;
      command_complete_flag_r <= 1'b1;
      protection_violation_flag_r <= 1'b0;
      access_error_flag_r <= 1'b0;
      blank_r <= 1'b0;
      div_r <= 7'h00;
      divld_r <= 1'b0;
      cfg_r <= 2'h0;
      op_start_r <= 1'b0;
      irq_be_r <= 1'b0;
      irq_cc_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      buf_r <= buf_nxt;
      act_r <= act_nxt;
      bufv_r <= bufv_nxt;
      busy_r <= busy_nxt;
      abort_r <= abort_nxt;
      cnt_r <= cnt_nxt;
      cbe_cnt_r <= cbe_cnt_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      buffer_empty_flag_r <= buffer_empty_flag_nxt;
      command_complete_flag_r <= command_complete_flag_nxt;
      protection_violation_flag_r <= protection_violation_flag_nxt;
      access_error_flag_r <= access_error_flag_nxt;
      blank_r <= blank_nxt;
      div_r <= div_nxt;
      divld_r <= divld_nxt;
      cfg_r <= cfg_nxt;
      op_start_r <= op_start_nxt;
      irq_be_r <= irq_be_nxt;
      irq_cc_r <= irq_cc_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign op_req = act_r;
  assign op_start = op_start_r;
  assign irq_buffer_empty = irq_be_r;
  assign irq_complete = irq_cc_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cbe_four_cycles: assert property (
    (launch_ok && buf_r.cmd != `EE_CMD_ABORT && !busy_r && !bufv_r && !abort_r) |->
      ##1 !buffer_empty_flag_r [*4] ##1 buffer_empty_flag_r)
    else $error("empty flag not set four cycles after launch");
  a_command_complete_flag_clr_launch: assert property (
    launch_ok |=> !command_complete_flag_r && !buffer_empty_flag_r)
    else $error("launch did not clear complete flag");
  a_cmd_rd_idle: assert property (
    (setup && !pwrite && paddr == `EE_OFF_CMD && seq_r == eecc_pkg::SEQ_IDLE) |=>
      prdata_r == 32'h0000_0000)
    else $error("command readable outside sequence");
  a_bad_cmd_err: assert property (
    (wr && seq_r == eecc_pkg::SEQ_ADDR && paddr == `EE_OFF_CMD && !in_array &&
     !is_valid_cmd(pwdata[6:0])) |=> access_error_flag_r && seq_r == eecc_pkg::SEQ_IDLE)
    else $error("invalid command not flagged");
  a_nodiv_err: assert property (
    (launch_try && !divld_r) |=> access_error_flag_r && !bufv_r && $stable(busy_r))
    else $error("command ran without divider load");
  a_divld_set: assert property (
    (wr && !in_array && paddr == `EE_OFF_DIV) |=> divld_r)
    else $error("divider write did not set loaded bit");
  a_zero_abort: assert property (
    (wr && seq_r != eecc_pkg::SEQ_IDLE && !in_array && paddr == `EE_OFF_STAT &&
     !wb[`EE_ST_BUFFER_EMPTY_FLAG]) |=> access_error_flag_r && seq_r == eecc_pkg::SEQ_IDLE)
    else $error("zero write did not abort sequence");
  a_protection_violation_flag_block: assert property (
    (protection_violation_flag_r && wr && in_array) |=> seq_r == eecc_pkg::SEQ_IDLE)
    else $error("launch while protection violation set");
  a_command_complete_flag_all_done: assert property (
    $rose(command_complete_flag_r) |-> !busy_r && !bufv_r)
    else $error("complete flag set with work pending");
  a_norm_buf_zero: assert property (
    (setup && !pwrite && !special_mode && paddr == `EE_OFF_DLO) |=>
      prdata_r == 32'h0000_0000)
    else $error("data buffer visible in normal mode");
  a_abort_holds: assert property (
    abort_r && !done |=> !buffer_empty_flag_r)
    else $error("empty flag set during abort");

  c_launch: cover property (launch_ok ##[1:40] op_start_r);
  c_queued: cover property (busy_r && launch_ok);
  c_abort: cover property (launch_ok && buf_r.cmd == `EE_CMD_ABORT && busy_r);
  c_complete: cover property ($rose(command_complete_flag_r));

endmodule
`default_nettype wire
